// [clksel_cfg_defines.vh]
// Purpose: constants of the input clock select configuration block
// Assumes: included by bare name from the design files
// Notes:   register offsets, reset values, field positions and codes
`ifndef CLKSEL_CFG_DEFINES_VH
`define CLKSEL_CFG_DEFINES_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_BW_RATE      8'h02
`define OFS_SEL_HOLD     8'h03
`define OFS_METHOD_HIST  8'h04

// ****************************************************************
// reset values
// ****************************************************************
`define RST_BW_RATE      8'h42
`define RST_SEL_HOLD     8'h05
`define RST_METHOD_HIST  8'h12
`define READ_UNMAPPED    8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define BW_MSB           7
`define BW_LSB           4
`define RATE_MSB         3
`define RATE_LSB         0
`define SEL_MSB          7
`define SEL_LSB          6
`define HOLD_BIT         5
`define SQ_BIT           4
`define RSV3_MSB         3
`define RSV3_LSB         0
`define METH_MSB         7
`define METH_LSB         6
`define RSV4_BIT         5
`define HIST_MSB         4
`define HIST_LSB         0

// ****************************************************************
// field codes
// ****************************************************************
`define RATE_37_41       4'h5
`define RATE_109_125     4'h6
`define SEL_ONE          2'h0
`define SEL_TWO          2'h1
`define METH_MANUAL      2'h0
`define METH_AUTO_NREV   2'h1
`define METH_AUTO_REV    2'h2

// ****************************************************************
// serial port
// ****************************************************************
`define BIT_LAST         3'h7
`define RW_READ          1'b1

`endif

// [cfg_serial_port.v]
// Purpose: two-wire serial slave giving byte access to the register file
// Assumes: scl and sda are asynchronous pins; bus clock well below clk_i/8
// Notes:   first byte device address, second register pointer, then data
`timescale 1ns/1ps
`default_nettype none
`include "clksel_cfg_defines.vh"

module cfg_serial_port #(
    parameter [6:0] DEV_ADDR = 7'h50              // arbitrary default
) (
    input  wire       clk_i,                      // 20 MHz clock
    input  wire       nrst_i,                     // async reset, active low
    input  wire       scl_i,                      // serial clock pin
    input  wire       sda_i,                      // serial data pin in
    output reg        sda_o,                      // serial data out level
    output reg        sda_oe_o,                   // high while driving sda
    output reg        wr_o,                       // one-cycle write strobe
    output reg  [7:0] wdata_o,                    // write data
    output reg  [7:0] ptr_o,                      // register pointer
    input  wire [7:0] rdata_i                     // read data at ptr_o
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RX   = 5'h02;
    localparam [4:0] ST_ACK  = 5'h04;
    localparam [4:0] ST_TX   = 5'h08;
    localparam [4:0] ST_MACK = 5'h10;
    localparam [1:0] PH_DEV  = 2'h0;
    localparam [1:0] PH_REG  = 2'h1;
    localparam [1:0] PH_DAT  = 2'h2;

    reg        scl_s1, scl_s2, scl_q;
    reg        sda_s1, sda_s2, sda_q;
    reg  [4:0] state;
    reg  [1:0] phase;
    reg  [2:0] bit_cnt;
    reg  [7:0] shift;
    reg        rw;
    reg        ack_on;
    wire [7:0] rx_byte = {shift[6:0], sda_s2};
    wire       scl_rise = scl_s2 & ~scl_q;
    wire       scl_fall = ~scl_s2 & scl_q;
    wire       start_c  = scl_s2 & scl_q & sda_q & ~sda_s2;
    wire       stop_c   = scl_s2 & scl_q & ~sda_q & sda_s2;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_q  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_q  <= 1'b1;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_q  <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_q  <= sda_s2;
        end
    end

    // ****************************************************************
    // byte engine
    // ****************************************************************
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state    <= ST_IDLE;
            phase    <= PH_DEV;
            bit_cnt  <= 3'h0;
            shift    <= 8'h00;
            rw       <= 1'b0;
            ack_on   <= 1'b0;
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_o     <= 1'b0;
            wdata_o  <= 8'h00;
            ptr_o    <= 8'h00;
        end else begin
            wr_o  <= 1'b0;
            sda_o <= 1'b0;                        // open drain: only pulls low
            if (start_c) begin
                state    <= ST_RX;
                phase    <= PH_DEV;
                bit_cnt  <= 3'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_c) begin
                state    <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state)
                    ST_RX: if (scl_rise) begin
                        shift   <= rx_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `BIT_LAST) begin
                            ack_on <= 1'b0;
                            state  <= ST_ACK;
                            case (phase)
                                PH_DEV: begin
                                    rw    <= rx_byte[0];
                                    phase <= PH_REG;
                                    if (rx_byte[7:1] != DEV_ADDR)
                                        state <= ST_IDLE;
                                end
                                PH_REG: begin
                                    ptr_o <= rx_byte;
                                    phase <= PH_DAT;
                                end
                                default: begin
                                    wr_o    <= 1'b1;
                                    wdata_o <= rx_byte;
                                end
                            endcase
                        end
                    end
                    ST_ACK: if (scl_fall) begin
                        if (!ack_on) begin
                            ack_on   <= 1'b1;
                            sda_oe_o <= 1'b1;
                        end else if (rw == `RW_READ) begin
                            shift    <= rdata_i;
                            sda_oe_o <= ~rdata_i[7];
                            ptr_o    <= ptr_o + 8'h01;
                            bit_cnt  <= 3'h0;
                            state    <= ST_TX;
                        end else begin
                            sda_oe_o <= 1'b0;
                            bit_cnt  <= 3'h0;
                            state    <= ST_RX;
                        end
                    end
                    ST_TX: if (scl_fall) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `BIT_LAST) begin
                            sda_oe_o <= 1'b0;
                            state    <= ST_MACK;
                        end else begin
                            shift    <= {shift[6:0], 1'b0};
                            sda_oe_o <= ~shift[6];
                        end
                    end
                    ST_MACK: if (scl_rise) begin
                        ack_on <= 1'b1;
                        state  <= sda_s2 ? ST_IDLE : ST_ACK;
                    end
                    ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    default: state <= ST_IDLE;
                endcase
                // pointer steps after each data byte written
                if (wr_o)
                    ptr_o <= ptr_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [clksel_cfg.v]
// Purpose: configuration registers for loop bandwidth, reference rate,
//          input clock selection, digital hold and calibration squelch
// Assumes: reached over the two-wire serial configuration port; the
//          calibration, auto-selection and output machinery is outside
// Notes:   every output comes from a flip-flop
// Functional notes
// (R1) bandwidth field takes effect only at calibration
// (R2) low nibble: reference range code 0101
// (R3) host writes 0110 for high range only
// (R4) manual register select: 00 one, 01 two
// (R5) pin select enabled: pin chooses, field ignored
// (R6) force hold overrides every selection
// (R7) squelch bit disables outputs during calibration
// (R8) method field: manual, non-revertive, revertive, reserved
// (R9) five-bit history delay field feeds hold history
// (R10) reset values 42, 05, 12 hex
// (R11) force-on keeps outputs despite squelch setting
// (R12) reserved bits read reset value, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "clksel_cfg_defines.vh"

module clksel_cfg #(
    parameter [6:0] DEV_ADDR = 7'h50              // arbitrary default
) (
    input  wire       clk_i,                      // 20 MHz reference-derived clock
    input  wire       nrst_i,                     // async reset, active low
    input  wire       scl_i,                      // serial clock pin
    input  wire       sda_i,                      // serial data pin in
    output wire       sda_o,                      // serial data out level
    output wire       sda_oe_o,                   // high while driving sda
    input  wire       select_input_pin_i,         // external select pin
    input  wire       pin_select_enable_i,        // pin select control
    input  wire       output_force_on_i,          // keep outputs on always
    input  wire       cal_start_i,                // calibration trigger pulse
    input  wire       cal_busy_i,                 // calibration running
    input  wire       auto_choice_i,              // auto selector's pick
    output reg  [3:0] loop_bw_o,                  // effective bandwidth
    output reg  [3:0] ref_rate_o,                 // reference rate code
    output reg        ref_rate_bad_o,             // reserved rate code held
    output reg  [1:0] selection_method_o,         // selection method field
    output reg  [4:0] history_delay_o,            // history delay field
    output reg        active_input_o,             // 0 input one, 1 input two
    output reg        digital_hold_o,             // forced digital hold
    output reg        outputs_enable_o            // output clocks enabled
);
    reg        pin_s1, pin_s2;
    reg  [3:0] loop_bw_select;
    reg  [1:0] input_select_field;
    reg        force_hold;
    reg        squelch_during_cal;
    wire       wr;
    wire [7:0] wdata;
    wire [7:0] ptr;
    reg  [7:0] rdata;

    // reset words, kept whole so fields are cut by part-select, not by shifts
    localparam [7:0] RST_BW_WORD   = `RST_BW_RATE;
    localparam [7:0] RST_SEL_WORD  = `RST_SEL_HOLD;
    localparam [7:0] RST_METH_WORD = `RST_METHOD_HIST;

    // true when the pointer addresses a mapped register
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `OFS_BW_RATE) || (a == `OFS_SEL_HOLD) ||
                        (a == `OFS_METHOD_HIST);
        end
    endfunction

    // ****************************************************************
    // serial configuration port
    // ****************************************************************
    cfg_serial_port #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe_o (sda_oe_o),
        .wr_o     (wr),
        .wdata_o  (wdata),
        .ptr_o    (ptr),
        .rdata_i  (rdata)
    );

    // ****************************************************************
    // register writes
    // ****************************************************************
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loop_bw_select     <= RST_BW_WORD[`BW_MSB:`BW_LSB];                       // R10
            ref_rate_o         <= RST_BW_WORD[`RATE_MSB:`RATE_LSB];                   // R10
            input_select_field <= RST_SEL_WORD[`SEL_MSB:`SEL_LSB];                    // R10
            force_hold         <= RST_SEL_WORD[`HOLD_BIT];
            squelch_during_cal <= RST_SEL_WORD[`SQ_BIT];
            selection_method_o <= RST_METH_WORD[`METH_MSB:`METH_LSB];                 // R10
            history_delay_o    <= RST_METH_WORD[`HIST_MSB:`HIST_LSB];                 // R10
        end else if (wr && is_mapped(ptr)) begin
            case (ptr)
                `OFS_BW_RATE: begin
                    loop_bw_select <= wdata[`BW_MSB:`BW_LSB];
                    ref_rate_o     <= wdata[`RATE_MSB:`RATE_LSB];                    // R2
                end
                `OFS_SEL_HOLD: begin
                    input_select_field <= wdata[`SEL_MSB:`SEL_LSB];
                    force_hold         <= wdata[`HOLD_BIT];
                    squelch_during_cal <= wdata[`SQ_BIT];
                end
                default: begin
                    selection_method_o <= wdata[`METH_MSB:`METH_LSB];                // R8
                    history_delay_o    <= wdata[`HIST_MSB:`HIST_LSB];                // R9
                end
            endcase
        end
    end

    // ****************************************************************
    // read mux; reserved bits return their reset values
    // ****************************************************************
    always @* begin
        rdata = `READ_UNMAPPED;
        case (ptr)
            `OFS_BW_RATE:     rdata = {loop_bw_select, ref_rate_o};
            `OFS_SEL_HOLD:    rdata = {input_select_field, force_hold, squelch_during_cal,
                                       RST_SEL_WORD[`RSV3_MSB:`RSV3_LSB]};            // R12
            `OFS_METHOD_HIST: rdata = {selection_method_o, RST_METH_WORD[`RSV4_BIT],
                                       history_delay_o};                              // R12
            default:          rdata = `READ_UNMAPPED;
        endcase
    end

    // ****************************************************************
    // select pin synchroniser
    // ****************************************************************
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= select_input_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    // ****************************************************************
    // effective bandwidth, latched only at a calibration trigger
    // ****************************************************************
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loop_bw_o <= RST_BW_WORD[`BW_MSB:`BW_LSB];
        end else if (cal_start_i) begin
            loop_bw_o <= loop_bw_select;                                              // R1
        end
    end

    // ****************************************************************
    // input selection and hold
    // ****************************************************************
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_input_o <= 1'b0;
            digital_hold_o <= 1'b0;
            ref_rate_bad_o <= 1'b0;
        end else begin
            digital_hold_o <= force_hold;                                             // R6
            // host must use only the two documented range codes
            ref_rate_bad_o <= (ref_rate_o != `RATE_37_41) &&
                              (ref_rate_o != `RATE_109_125);                          // R3
            if (force_hold) begin
                active_input_o <= active_input_o;                                     // R6
            end else begin
                case (selection_method_o)
                    `METH_MANUAL: begin
                        if (pin_select_enable_i)
                            active_input_o <= pin_s2;                                 // R5
                        else if (input_select_field == `SEL_ONE)
                            active_input_o <= 1'b0;                                   // R4
                        else if (input_select_field == `SEL_TWO)
                            active_input_o <= 1'b1;                                   // R4
                    end
                    `METH_AUTO_NREV: active_input_o <= auto_choice_i;                 // R8
                    `METH_AUTO_REV:  active_input_o <= auto_choice_i;                 // R8
                    default:         active_input_o <= active_input_o;
                endcase
            end
        end
    end

    // ****************************************************************
    // output squelch during calibration
    // ****************************************************************
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            outputs_enable_o <= 1'b0;
        end else begin
            outputs_enable_o <= output_force_on_i ||                                  // R11
                                !(squelch_during_cal && cal_busy_i);                  // R7
        end
    end
endmodule
`default_nettype wire

// [clksel_cfg_chk.sv]
// Purpose: assertions on the clock select configuration outputs
// Assumes: bound to clksel_cfg, one clock domain
// Notes:   all checks are off while nrst_i is low
`timescale 1ns/1ps
`default_nettype none
module clksel_cfg_chk (
    input wire logic       clk_i,               // clock
    input wire logic       nrst_i,              // async reset, low
    input wire logic       select_input_pin_i,  // select pin
    input wire logic       pin_select_enable_i, // pin select control
    input wire logic       output_force_on_i,   // force outputs on
    input wire logic       cal_start_i,         // calibration pulse
    input wire logic       cal_busy_i,          // calibration running
    input wire logic       auto_choice_i,       // auto pick
    input wire logic [3:0] loop_bw_o,           // bandwidth
    input wire logic [3:0] ref_rate_o,          // rate code
    input wire logic       ref_rate_bad_o,      // bad rate flag
    input wire logic [1:0] selection_method_o,  // method
    input wire logic       active_input_o,      // active input
    input wire logic       digital_hold_o,      // hold
    input wire logic       outputs_enable_o     // outputs on
);
// ********
// properties
// ********
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
// bandwidth only moves on the clock after a calibration pulse
a_bw_after_cal: assert property (!$stable(loop_bw_o) |-> $past(cal_start_i))
    else $error("bandwidth changed without calibration");
a_rate_good: assert property ((ref_rate_o inside {4'h5, 4'h6}) [*2] |-> !ref_rate_bad_o)
    else $error("valid rate code flagged");
a_rate_bad: assert property ((nrst_i && !(ref_rate_o inside {4'h5, 4'h6})) [*2] |-> ref_rate_bad_o)
    else $error("reserved rate code not flagged");
a_hold_freeze: assert property (digital_hold_o [*2] |-> $stable(active_input_o))
    else $error("active input moved during hold");
// windows are long enough to cover the pin synchroniser lag
a_pin_follow: assert property ((selection_method_o == 2'h0 && pin_select_enable_i && !digital_hold_o
    && $stable(select_input_pin_i)) [*5] |-> active_input_o == select_input_pin_i)
    else $error("active input not following pin");
a_auto_follow: assert property ((selection_method_o inside {2'h1, 2'h2} && !digital_hold_o
    && $stable(auto_choice_i)) [*3] |-> active_input_o == auto_choice_i)
    else $error("active input not following auto pick");
a_idle_on: assert property ($past(nrst_i) && !$past(cal_busy_i) |-> outputs_enable_o)
    else $error("outputs off outside calibration");
a_force_on: assert property ($past(output_force_on_i) |-> outputs_enable_o)
    else $error("outputs off while forced on");
endmodule
`default_nettype wire

// [clksel_cfg_tb_top.sv]
// Purpose: self-checking bench for the clock select configuration block
// Assumes: two-wire port with pull-up; bus phases of 10 clocks
// Notes:   random fields from a fixed seed, corner codes by hand
`timescale 1ns/1ps
`default_nettype none
module clksel_cfg_tb_top;
localparam logic [6:0] DEV = 7'h50;  // arbitrary device address
logic       clk_i, nrst_i, scl_m, sda_m, pin, pen, fon, cal_go, busy, auto_c;
logic [3:0] eb;
int         error_cnt, total_checks, seed;
wire        sda_o, sda_oe_o, ref_rate_bad_o, active_input_o, digital_hold_o, outputs_enable_o;
wire  [3:0] loop_bw_o, ref_rate_o;
wire  [1:0] selection_method_o;
wire  [4:0] history_delay_o;
wire        sda_line;
// open-drain wire with pull-up
assign sda_line = sda_m & ~(sda_oe_o & ~sda_o);
clksel_cfg #(.DEV_ADDR(DEV)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_m), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .select_input_pin_i(pin), .pin_select_enable_i(pen),
    .output_force_on_i(fon), .cal_start_i(cal_go), .cal_busy_i(busy), .auto_choice_i(auto_c),
    .loop_bw_o(loop_bw_o), .ref_rate_o(ref_rate_o), .ref_rate_bad_o(ref_rate_bad_o),
    .selection_method_o(selection_method_o), .history_delay_o(history_delay_o),
    .active_input_o(active_input_o), .digital_hold_o(digital_hold_o), .outputs_enable_o(outputs_enable_o));
// ********
// tasks
// ********
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
        error_cnt++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task automatic ph;
    repeat (10) @(posedge clk_i);
endtask
// let outputs settle, then look between edges
task automatic settle;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
endtask
// sda only moves mid low phase, never beside an scl edge
task automatic bitx(input logic b, output logic r);
    ph;
    sda_m <= b;
    ph;
    scl_m <= 1'b1;
    ph;
    r = sda_line;
    scl_m <= 1'b0;
endtask
task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, a);
endtask
task automatic start;
    ph;
    sda_m <= 1'b1;
    ph;
    scl_m <= 1'b1;
    ph;
    sda_m <= 1'b0;
    ph;
    scl_m <= 1'b0;
endtask
task automatic stop;
    ph;
    sda_m <= 1'b0;
    ph;
    scl_m <= 1'b1;
    ph;
    sda_m <= 1'b1;
    ph;
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       k0, k1, k2;
    start;
    xfer({DEV, 1'b0}, q, k0);
    xfer(a, q, k1);
    xfer(d, q, k2);
    stop;
    chk("write ack", 8'h00, {7'h0, k0 | k1 | k2});
endtask
task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q, x;
    logic       k0, k1, k2, n;
    start;
    xfer({DEV, 1'b0}, x, k0);
    xfer(a, x, k1);
    start;
    xfer({DEV, 1'b1}, x, k2);
    xfer(8'hff, q, n);
    stop;
    chk("read ack", 8'h00, {7'h0, k0 | k1 | k2});
    chk(nm, e, q);
endtask
task automatic pulse_cal;
    @(posedge clk_i);
    cal_go <= 1'b1;
    @(posedge clk_i);
    cal_go <= 1'b0;
endtask
// ********
// stimulus
// ********
initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
end
initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    end_sim;
end
initial begin
    logic [7:0] v;
    {nrst_i, pin, pen, fon, cal_go, busy, auto_c} = 7'h0;
    {scl_m, sda_m} = 2'b11;
    {error_cnt, total_checks, seed} = {32'h0, 32'h0, 32'h0348};
    eb = 4'h4;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdc(8'h02, 8'h42, "reg2 reset");
    rdc(8'h03, 8'h05, "reg3 reset");
    rdc(8'h04, 8'h12, "reg4 reset");
    rdc(8'h07, 8'h00, "unmapped read");
    chk("bw reset", 8'h04, {4'h0, loop_bw_o});
    chk("history reset", 8'h12, {3'h0, history_delay_o});
    $display("reset test done");
    // bandwidth waits for calibration; both valid rate codes
    for (int i = 0; i < 4; i++) begin
        v = 8'($random(seed));
        v[3:0] = i[0] ? 4'h6 : 4'h5;
        wr(8'h02, v);
        settle;
        chk("rate code", {4'h0, v[3:0]}, {4'h0, ref_rate_o});
        chk("rate flag", 8'h00, {7'h0, ref_rate_bad_o});
        chk("bw before cal", {4'h0, eb}, {4'h0, loop_bw_o});
        pulse_cal;
        eb = v[7:4];
        settle;
        chk("bw after cal", {4'h0, eb}, {4'h0, loop_bw_o});
        rdc(8'h02, v, "reg2 readback");
    end
    wr(8'h02, 8'h39);
    settle;
    chk("reserved rate flag", 8'h01, {7'h0, ref_rate_bad_o});
    $display("bandwidth test done");
    // register select, reserved low nibble, then pin select
    for (int s = 0; s < 2; s++) begin
        v = 8'($random(seed));
        v[7:4] = {s[1:0], 2'b00};
        wr(8'h03, v);
        settle;
        chk("register select", {7'h0, s[0]}, {7'h0, active_input_o});
        rdc(8'h03, {v[7:4], 4'h5}, "reg3 reserved bits");
    end
    pen <= 1'b1;
    for (int p = 0; p < 2; p++) begin
        @(posedge clk_i);
        pin <= p[0];
        settle;
        chk("pin select", {7'h0, p[0]}, {7'h0, active_input_o});
    end
    // hold freezes input two selection against pin and auto pick
    wr(8'h03, 8'h60);
    pin <= 1'b0;
    wr(8'h04, 8'h52);
    settle;
    chk("hold flag", 8'h01, {7'h0, digital_hold_o});
    chk("hold frozen", 8'h01, {7'h0, active_input_o});
    wr(8'h03, 8'h40);
    $display("select test done");
    // automatic methods and reserved method 11, reserved bit 5 and history field
    for (int m = 1; m < 4; m++) begin
        v = 8'($random(seed));
        v[7:5] = {m[1:0], 1'b1};
        wr(8'h04, v);
        rdc(8'h04, {v[7:6], 1'b0, v[4:0]}, "reg4 readback");
        chk("history delay", {3'h0, v[4:0]}, {3'h0, history_delay_o});
        chk("method", {6'h0, v[7:6]}, {6'h0, selection_method_o});
        for (int c = 0; c < 2; c++) begin
            @(posedge clk_i);
            auto_c <= ~c[0];
            settle;
            chk("auto pick", {7'h0, m == 3 ? 1'b0 : ~c[0]}, {7'h0, active_input_o});
        end
    end
    $display("method test done");
    // squelch during calibration, then forced on
    wr(8'h03, 8'h50);
    busy <= 1'b1;
    settle;
    chk("squelched", 8'h00, {7'h0, outputs_enable_o});
    @(posedge clk_i);
    fon <= 1'b1;
    settle;
    chk("forced on", 8'h01, {7'h0, outputs_enable_o});
    @(posedge clk_i);
    fon <= 1'b0;
    wr(8'h03, 8'h40);
    settle;
    chk("no squelch", 8'h01, {7'h0, outputs_enable_o});
    @(posedge clk_i);
    busy <= 1'b0;
    $display("squelch test done");
    end_sim;
end
endmodule
bind clksel_cfg clksel_cfg_chk chk_u (.*);
`default_nettype wire
